// [hdl/bsa_defines.svh]
// Purpose: constants of the slice array and its end controller
// Assumes: one clock, synchronous reset
// Notes: byte offsets of the controller's registers
`ifndef BSA_DEFINES_SVH
`define BSA_DEFINES_SVH
`define BSA_SLICE_W 4
`define BSA_NUM_SLICES 4
`define BSA_DATA_W 16
`define BSA_ADDR_W 4
`define BSA_REG_MICRO 4'h0
`define BSA_REG_STATUS 4'h4
`define BSA_REG_MASK 4'h8
`define BSA_REG_FLAGS 4'hc
`define BSA_MW_DATA_LSB 0
`define BSA_MW_OP_LSB 16
`define BSA_MW_DEST_LSB 18
`define BSA_MW_QSH_BIT 20
`define BSA_MW_MODE_LSB 21
`define BSA_MW_CIN_BIT 23
`define BSA_FLAG_ZERO 0
`define BSA_FLAG_OVF 1
`define BSA_FLAG_NEG 2
`define BSA_FLAG_CARRY 3
`define BSA_FLAG_W 4
`define BSA_MASK_RST 4'h0
`endif

// [hdl/bsa_pkg.sv]
// Purpose: types shared by both ends of the slice array link
// Assumes: nothing
// Notes: enum order is the microword encoding
package bsa_pkg;
  typedef enum logic [1:0] {BSA_OP_ADD, BSA_OP_SUB, BSA_OP_PASS_D, BSA_OP_PASS_ACC} bsa_op_e;
  typedef enum logic [1:0] {BSA_DEST_LOAD, BSA_DEST_HOLD, BSA_DEST_UP, BSA_DEST_DOWN} bsa_dest_e;
  typedef enum logic [1:0] {BSA_SM_ZERO, BSA_SM_ONE, BSA_SM_ROTATE, BSA_SM_ARITH} bsa_smode_e;
endpackage : bsa_pkg

// [hdl/bsa_link_if.sv]
// Purpose: link between the slice array and its end controller
// Assumes: both parties clocked by the same clock
// Notes: shift end lines resolved here from the two enables
`timescale 1ns/10ps
`default_nettype none
`include "bsa_defines.svh"
interface bsa_link_if;
  import bsa_pkg::*;
  // pipelined microword
  bsa_op_e micro_op;
  bsa_dest_e micro_dest;
  logic micro_q_shift;
  logic carry_in_line;
  logic [`BSA_DATA_W-1:0] micro_data;
  logic micro_valid;
  // slice side of the end shift lines
  logic alu_lo_dev_o, alu_lo_dev_oe, alu_hi_dev_o, alu_hi_dev_oe;
  logic reg_lo_dev_o, reg_lo_dev_oe, reg_hi_dev_o, reg_hi_dev_oe;
  // end multiplexer side
  logic alu_lo_mux_o, alu_lo_mux_oe, alu_hi_mux_o, alu_hi_mux_oe;
  logic reg_lo_mux_o, reg_lo_mux_oe, reg_hi_mux_o, reg_hi_mux_oe;
  // resolved levels; undriven line is pulled high
  logic alu_shift_low_end, alu_shift_high_end, reg_shift_low_end, reg_shift_high_end;
  logic shift_direction_bit;
  logic shift_active;
  logic result_sign_bit;
  logic [`BSA_FLAG_W-1:0] flags;
  logic flags_valid;
  assign alu_shift_low_end = alu_lo_dev_oe ? alu_lo_dev_o : (alu_lo_mux_oe ? alu_lo_mux_o : 1'b1);
  assign alu_shift_high_end = alu_hi_dev_oe ? alu_hi_dev_o : (alu_hi_mux_oe ? alu_hi_mux_o : 1'b1);
  assign reg_shift_low_end = reg_lo_dev_oe ? reg_lo_dev_o : (reg_lo_mux_oe ? reg_lo_mux_o : 1'b1);
  assign reg_shift_high_end = reg_hi_dev_oe ? reg_hi_dev_o : (reg_hi_mux_oe ? reg_hi_mux_o : 1'b1);
  modport dev (
    input micro_op, micro_dest, micro_q_shift, carry_in_line, micro_data, micro_valid,
    input alu_shift_low_end, alu_shift_high_end, reg_shift_low_end, reg_shift_high_end,
    output alu_lo_dev_o, alu_lo_dev_oe, alu_hi_dev_o, alu_hi_dev_oe,
    output reg_lo_dev_o, reg_lo_dev_oe, reg_hi_dev_o, reg_hi_dev_oe,
    output shift_direction_bit, shift_active, result_sign_bit, flags, flags_valid
  );
  modport ctl (
    output micro_op, micro_dest, micro_q_shift, carry_in_line, micro_data, micro_valid,
    input alu_shift_low_end, alu_shift_high_end, reg_shift_low_end, reg_shift_high_end,
    output alu_lo_mux_o, alu_lo_mux_oe, alu_hi_mux_o, alu_hi_mux_oe,
    output reg_lo_mux_o, reg_lo_mux_oe, reg_hi_mux_o, reg_hi_mux_oe,
    input shift_direction_bit, shift_active, result_sign_bit, flags, flags_valid
  );
endinterface : bsa_link_if
`default_nettype wire

// [hdl/bsa_array.sv]
// Purpose: cascade of four-bit slices forming the wide datapath
// Assumes: microword arrives from a pipeline register on this clock
// Notes: slice internals reduced to an accumulator, a shift register and an adder
`timescale 1ns/10ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_slice (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire bsa_pkg::bsa_op_e i_op,
  input wire bsa_pkg::bsa_dest_e i_dest,
  input wire logic i_q_shift,
  input wire logic [`BSA_SLICE_W-1:0] i_d,
  input wire logic i_cin,
  input wire logic i_alu_lo,
  input wire logic i_alu_hi,
  input wire logic i_reg_lo,
  input wire logic i_reg_hi,
  output logic [`BSA_SLICE_W-1:0] o_f,
  output logic [`BSA_SLICE_W-1:0] o_acc,
  output logic [`BSA_SLICE_W-1:0] o_q,
  output logic o_cout,
  output logic o_c_sign,
  output logic o_g,
  output logic o_p
);
  import bsa_pkg::*;
  logic [`BSA_SLICE_W-1:0] b;
  logic [3:0] s_lo;
  logic [1:0] s_hi;
  logic [4:0] s_gen;
  logic arith;
  always_comb begin
    arith = (i_op == BSA_OP_ADD) || (i_op == BSA_OP_SUB);
    b = (i_op == BSA_OP_SUB) ? ~i_d : i_d;
    s_lo = {1'b0, o_acc[2:0]} + {1'b0, b[2:0]} + {3'h0, i_cin};
    s_hi = {1'b0, o_acc[3]} + {1'b0, b[3]} + {1'b0, s_lo[3]};
    s_gen = {1'b0, o_acc} + {1'b0, b};
    o_c_sign = arith & s_lo[3];
    o_cout = arith & s_hi[1];
    o_g = arith & s_gen[4];
    o_p = arith & (&(o_acc ^ b));
    case (i_op)
      BSA_OP_PASS_D: o_f = i_d;
      BSA_OP_PASS_ACC: o_f = o_acc;
      default: o_f = {s_hi[0], s_lo[2:0]};
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_acc <= 4'h0;
    end else begin
      case (i_dest)
        BSA_DEST_LOAD: o_acc <= o_f;
        BSA_DEST_UP: o_acc <= {o_f[2:0], i_alu_lo};
        BSA_DEST_DOWN: o_acc <= {i_alu_hi, o_f[3:1]};
        default: o_acc <= o_acc;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_q <= 4'h0;
    end else if (i_q_shift) begin
      case (i_dest)
        BSA_DEST_LOAD: o_q <= o_f;
        BSA_DEST_UP: o_q <= {o_q[2:0], i_reg_lo};
        BSA_DEST_DOWN: o_q <= {i_reg_hi, o_q[3:1]};
        default: o_q <= o_q;
      endcase
    end
  end
endmodule : bsa_slice

module bsa_array #(
  parameter bit CARRY_LOOKAHEAD = 1'b0
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  bsa_link_if.dev lnk,
  output logic [`BSA_DATA_W-1:0] o_result,
  output logic [`BSA_DATA_W-1:0] o_q,
  output logic [`BSA_FLAG_W-1:0] o_flags
);
  import bsa_pkg::*;
  localparam int N = `BSA_NUM_SLICES;
  localparam int W = `BSA_SLICE_W;
  logic [`BSA_DATA_W-1:0] f;
  logic [N:0] c;
  logic [N-1:0] cout, c_sign, g, p, alu_lo, alu_hi, reg_lo, reg_hi;
  logic up, down;
  assign up = (lnk.micro_dest == BSA_DEST_UP);
  assign down = (lnk.micro_dest == BSA_DEST_DOWN);
  assign c[0] = lnk.carry_in_line;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_slice
      // all slices share op, dest and shift select
      bsa_slice u_slice (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_op(lnk.micro_op),
        .i_dest(lnk.micro_dest),
        .i_q_shift(lnk.micro_q_shift),
        .i_d(lnk.micro_data[i*W +: W]),
        .i_cin(c[i]),
        .i_alu_lo(alu_lo[i]),
        .i_alu_hi(alu_hi[i]),
        .i_reg_lo(reg_lo[i]),
        .i_reg_hi(reg_hi[i]),
        .o_f(f[i*W +: W]),
        .o_acc(o_result[i*W +: W]),
        .o_q(o_q[i*W +: W]),
        .o_cout(cout[i]),
        .o_c_sign(c_sign[i]),
        .o_g(g[i]),
        .o_p(p[i])
      );
      // neighbour shift lines form one contiguous word
      if (i == 0) begin : g_lo
        assign alu_lo[i] = lnk.alu_shift_low_end;
        assign reg_lo[i] = lnk.reg_shift_low_end;
      end else begin : g_lo_link
        assign alu_lo[i] = f[i*W-1];
        assign reg_lo[i] = o_q[i*W-1];
      end
      if (i == N-1) begin : g_hi
        assign alu_hi[i] = lnk.alu_shift_high_end;
        assign reg_hi[i] = lnk.reg_shift_high_end;
      end else begin : g_hi_link
        assign alu_hi[i] = f[(i+1)*W];
        assign reg_hi[i] = o_q[(i+1)*W];
      end
      if (CARRY_LOOKAHEAD) begin : g_cla
        assign c[i+1] = g[i] | (p[i] & c[i]);
      end else begin : g_rip
        assign c[i+1] = cout[i];
      end
    end
  endgenerate
  // slice drives only the end it shifts out of; the mux owns the other
  assign lnk.alu_hi_dev_o = f[`BSA_DATA_W-1];
  assign lnk.alu_hi_dev_oe = up;
  assign lnk.reg_hi_dev_o = o_q[`BSA_DATA_W-1];
  assign lnk.reg_hi_dev_oe = up;
  assign lnk.alu_lo_dev_o = f[0];
  assign lnk.alu_lo_dev_oe = down;
  assign lnk.reg_lo_dev_o = o_q[0];
  assign lnk.reg_lo_dev_oe = down;
  assign lnk.shift_direction_bit = up;
  assign lnk.shift_active = up | down;
  assign lnk.result_sign_bit = f[`BSA_DATA_W-1];
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_flags <= 4'h0;
    end else if (lnk.micro_valid) begin
      o_flags[`BSA_FLAG_ZERO] <= ~|f;
      o_flags[`BSA_FLAG_OVF] <= c_sign[N-1] ^ cout[N-1];
      o_flags[`BSA_FLAG_NEG] <= f[`BSA_DATA_W-1];
      // lookahead group carry is the faster path for the flag
      o_flags[`BSA_FLAG_CARRY] <= CARRY_LOOKAHEAD ? c[N] : cout[N-1];
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lnk.flags_valid <= 1'b0;
    end else begin
      lnk.flags_valid <= lnk.micro_valid;
    end
  end
  assign lnk.flags = o_flags;
endmodule : bsa_array
`default_nettype wire

// [hdl/bsa_end_ctrl.sv]
// Purpose: pipeline register and end-of-array shift multiplexers
// Assumes: software issues microwords through a plain register port
// Notes: status events are sticky and cleared by reading them
`timescale 1ns/10ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_end_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [`BSA_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  bsa_link_if.ctl lnk
);
  import bsa_pkg::*;
  bsa_smode_e shift_mode;
  logic [`BSA_FLAG_W-1:0] status;
  logic [`BSA_FLAG_W-1:0] mask;
  logic [`BSA_FLAG_W-1:0] last_flags;
  logic [`BSA_FLAG_W-1:0] next_status;
  logic wr_micro;
  logic rd_status;
  logic up_sel;
  logic down_sel;
  logic mux_up_alu;
  logic mux_up_reg;
  logic mux_down_alu;
  logic mux_down_reg;

  assign wr_micro = i_wr && (i_addr == `BSA_REG_MICRO);
  assign rd_status = i_rd && (i_addr == `BSA_REG_STATUS);

  // the microword is held one cycle, then falls back to a hold nop;
  // the array executes in the cycle after the write
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      lnk.micro_op <= BSA_OP_PASS_ACC;
      lnk.micro_dest <= BSA_DEST_HOLD;
      lnk.micro_q_shift <= 1'b0;
      lnk.carry_in_line <= 1'b0;
      lnk.micro_data <= 16'h0000;
      lnk.micro_valid <= 1'b0;
    end else if (wr_micro) begin
      lnk.micro_op <= bsa_op_e'(i_wdata[`BSA_MW_OP_LSB +: 2]);
      lnk.micro_dest <= bsa_dest_e'(i_wdata[`BSA_MW_DEST_LSB +: 2]);
      lnk.micro_q_shift <= i_wdata[`BSA_MW_QSH_BIT];
      lnk.carry_in_line <= i_wdata[`BSA_MW_CIN_BIT];
      lnk.micro_data <= i_wdata[`BSA_MW_DATA_LSB +: `BSA_DATA_W];
      lnk.micro_valid <= 1'b1;
    end else begin
      lnk.micro_op <= BSA_OP_PASS_ACC;
      lnk.micro_dest <= BSA_DEST_HOLD;
      lnk.micro_q_shift <= 1'b0;
      lnk.carry_in_line <= 1'b0;
      lnk.micro_valid <= 1'b0;
    end
  end

  // mode field rides in the same pipeline stage as the rest
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      shift_mode <= BSA_SM_ZERO;
    end else if (wr_micro) begin
      shift_mode <= bsa_smode_e'(i_wdata[`BSA_MW_MODE_LSB +: 2]);
    end
  end

  // direction bit from the slices enables exactly one end
  assign up_sel = lnk.shift_active & lnk.shift_direction_bit;
  assign down_sel = lnk.shift_active & ~lnk.shift_direction_bit;

  // up shift: new bits enter at the low end of both shifters
  always_comb begin
    case (shift_mode)
      BSA_SM_ZERO: begin
        mux_up_alu = 1'b0;
        mux_up_reg = 1'b0;
      end
      BSA_SM_ONE: begin
        mux_up_alu = 1'b1;
        mux_up_reg = 1'b1;
      end
      BSA_SM_ROTATE: begin
        mux_up_alu = lnk.alu_shift_high_end;
        mux_up_reg = lnk.reg_shift_high_end;
      end
      BSA_SM_ARITH: begin
        mux_up_alu = lnk.reg_shift_high_end;
        mux_up_reg = 1'b0;
      end
      default: begin
        mux_up_alu = 1'b0;
        mux_up_reg = 1'b0;
      end
    endcase
  end

  // down shift: new bits enter at the high end of both shifters
  always_comb begin
    case (shift_mode)
      BSA_SM_ZERO: begin
        mux_down_alu = 1'b0;
        mux_down_reg = 1'b0;
      end
      BSA_SM_ONE: begin
        mux_down_alu = 1'b1;
        mux_down_reg = 1'b1;
      end
      BSA_SM_ROTATE: begin
        mux_down_alu = lnk.alu_shift_low_end;
        mux_down_reg = lnk.reg_shift_low_end;
      end
      BSA_SM_ARITH: begin
        // sign copied so the shifted value keeps its sign
        mux_down_alu = lnk.result_sign_bit;
        mux_down_reg = lnk.alu_shift_low_end;
      end
      default: begin
        mux_down_alu = 1'b0;
        mux_down_reg = 1'b0;
      end
    endcase
  end

  // end multiplexers drive only the vacated ends; the slices own
  // the shift-out ends, so no line ever sees two drivers
  assign lnk.alu_lo_mux_o = mux_up_alu;
  assign lnk.alu_lo_mux_oe = up_sel;
  assign lnk.reg_lo_mux_o = mux_up_reg;
  assign lnk.reg_lo_mux_oe = up_sel;
  assign lnk.alu_hi_mux_o = mux_down_alu;
  assign lnk.alu_hi_mux_oe = down_sel;
  assign lnk.reg_hi_mux_o = mux_down_reg;
  assign lnk.reg_hi_mux_oe = down_sel;

  // flags as reported for the last executed microword
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      last_flags <= 4'h0;
    end else if (lnk.flags_valid) begin
      last_flags <= lnk.flags;
    end
  end

  // a flag seen in the same cycle as the clearing read survives
  always_comb begin
    next_status = status;
    if (rd_status) begin
      next_status = 4'h0;
    end
    if (lnk.flags_valid) begin
      next_status = next_status | lnk.flags;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status <= 4'h0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mask <= `BSA_MASK_RST;
    end else if (i_wr && (i_addr == `BSA_REG_MASK)) begin
      mask <= i_wdata[`BSA_FLAG_W-1:0];
    end
  end

  // registered level; changes in the same cycle as the status
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_status & mask);
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `BSA_REG_STATUS: o_rdata <= {28'h0000000, status};
        `BSA_REG_MASK: o_rdata <= {28'h0000000, mask};
        `BSA_REG_FLAGS: o_rdata <= {28'h0000000, last_flags};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule : bsa_end_ctrl
`default_nettype wire

// [bench/bsa_link_props.sv]
// Purpose: concurrent checks on the link between slice array and end controller
// Assumes: one clock, synchronous active-low reset
// Notes: sees link signals only; instantiated beside the interface
`timescale 1ns/10ps
`default_nettype none
`include "bsa_defines.svh"
module bsa_link_props (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire bsa_pkg::bsa_op_e micro_op,
  input wire logic [`BSA_DATA_W-1:0] micro_data,
  input wire logic micro_valid,
  input wire logic alu_lo_dev_oe,
  input wire logic alu_hi_dev_oe,
  input wire logic reg_lo_dev_oe,
  input wire logic reg_hi_dev_oe,
  input wire logic alu_lo_mux_oe,
  input wire logic alu_hi_mux_oe,
  input wire logic reg_lo_mux_oe,
  input wire logic reg_hi_mux_oe,
  input wire logic alu_shift_high_end,
  input wire logic shift_direction_bit,
  input wire logic shift_active,
  input wire logic result_sign_bit,
  input wire logic [`BSA_FLAG_W-1:0] flags,
  input wire logic flags_valid
);
  import bsa_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_exec;
    micro_valid ##1 flags_valid;
  endsequence
  sequence s_pass;
    micro_valid && micro_op == BSA_OP_PASS_D;
  endsequence
  a_exec_flags: assert property (micro_valid |-> s_exec)
    else $error("flags not reported one cycle after microword");
  a_flags_only_exec: assert property ($changed(flags) |-> flags_valid)
    else $error("flags changed without an executed microword");
  a_pass_zero: assert property (s_pass |=> flags[`BSA_FLAG_ZERO] == ($past(micro_data) == '0))
    else $error("zero flag wrong after pass");
  a_pass_neg: assert property (s_pass |=> flags[`BSA_FLAG_NEG] == $past(micro_data[15]))
    else $error("negative flag wrong after pass");
  a_pass_no_ovf: assert property (s_pass |=> !flags[`BSA_FLAG_OVF] && !flags[`BSA_FLAG_CARRY])
    else $error("overflow or carry set by pass");
  a_up_low_mux: assert property (shift_active && shift_direction_bit
    |-> alu_lo_mux_oe && reg_lo_mux_oe && !alu_hi_mux_oe && !reg_hi_mux_oe)
    else $error("wrong end multiplexer on up shift");
  a_down_high_mux: assert property (shift_active && !shift_direction_bit
    |-> alu_hi_mux_oe && reg_hi_mux_oe && !alu_lo_mux_oe && !reg_lo_mux_oe)
    else $error("wrong end multiplexer on down shift");
  a_one_driver: assert property (!(alu_lo_dev_oe && alu_lo_mux_oe) && !(alu_hi_dev_oe && alu_hi_mux_oe)
    && !(reg_lo_dev_oe && reg_lo_mux_oe) && !(reg_hi_dev_oe && reg_hi_mux_oe))
    else $error("shift line driven from both sides");
  a_up_sign_out: assert property (shift_active && shift_direction_bit
    |-> alu_shift_high_end == result_sign_bit)
    else $error("top shift line not the result sign on up shift");
endmodule : bsa_link_props
`default_nettype wire

// [bench/bit_slice_array_expansion_test.sv]
// Purpose: self-checking bench joining slice array and end controller
// Assumes: 200 MHz clock, registers reached through the plain port
// Notes: expectations worked out from flag and shift-mode behaviour
`timescale 1ns/10ps
`default_nettype none
`include "bsa_defines.svh"
module bit_slice_array_expansion_test;
  import bsa_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_irq;
  logic [15:0] o_result;
  logic [15:0] o_q;
  logic [3:0] o_flags;
  logic [15:0] o_result_cla;
  logic [15:0] o_q_cla;
  logic [3:0] o_flags_cla;
  logic [31:0] rv;
  logic a;
  logic qi;
  // bit inserted at the vacated end, indexed by shift mode
  localparam logic [3:0] BIT_IN_A = 4'b1010;
  localparam logic [3:0] BIT_IN_B = 4'b0110;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  bsa_link_if lnk ();
  bsa_array i_bsa_array (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .lnk(lnk.dev),
    .o_result(o_result), .o_q(o_q), .o_flags(o_flags));
  bsa_end_ctrl i_bsa_end_ctrl (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .lnk(lnk.ctl));
  // second array on lookahead carry, fed the same register writes
  bsa_link_if lnk_cla ();
  bsa_array #(.CARRY_LOOKAHEAD(1'b1)) i_bsa_array_cla (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .lnk(lnk_cla.dev), .o_result(o_result_cla), .o_q(o_q_cla), .o_flags(o_flags_cla));
  bsa_end_ctrl i_bsa_end_ctrl_cla (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(), .o_irq(), .lnk(lnk_cla.ctl));
  bsa_link_props i_bsa_link_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .micro_op(lnk.micro_op),
    .micro_data(lnk.micro_data), .micro_valid(lnk.micro_valid), .alu_lo_dev_oe(lnk.alu_lo_dev_oe),
    .alu_hi_dev_oe(lnk.alu_hi_dev_oe), .reg_lo_dev_oe(lnk.reg_lo_dev_oe), .reg_hi_dev_oe(lnk.reg_hi_dev_oe),
    .alu_lo_mux_oe(lnk.alu_lo_mux_oe), .alu_hi_mux_oe(lnk.alu_hi_mux_oe), .reg_lo_mux_oe(lnk.reg_lo_mux_oe),
    .reg_hi_mux_oe(lnk.reg_hi_mux_oe), .alu_shift_high_end(lnk.alu_shift_high_end),
    .shift_direction_bit(lnk.shift_direction_bit), .shift_active(lnk.shift_active),
    .result_sign_bit(lnk.result_sign_bit), .flags(lnk.flags), .flags_valid(lnk.flags_valid));
  always #2.5 i_sys_clk = ~i_sys_clk;
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // whole run needs under 150 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] ad, input logic [31:0] d);
    i_addr <= ad;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [31:0] d);
    i_addr <= ad;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_sys_clk);
  endtask : rd
  task automatic irq_is(input logic e);
    #1;
    check({15'h0, o_irq}, {15'h0, e});
    @(posedge i_sys_clk);
  endtask : irq_is
  function automatic logic [23:0] mw(input logic cin, input bsa_smode_e m, input logic qs, input bsa_dest_e de,
    input bsa_op_e op, input logic [15:0] d);
    return {cin, m, qs, de, op, d};
  endfunction : mw
  // issue a microword, then look once status and irq have landed
  task automatic exec(input logic [23:0] w, input logic [15:0] er, input logic [15:0] eq,
    input logic [3:0] ef, input logic ei);
    wr(`BSA_REG_MICRO, {8'h0, w});
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(o_result, er);
    check(o_q, eq);
    check({12'h0, o_flags}, {12'h0, ef});
    check({15'h0, o_irq}, {15'h0, ei});
    check(o_result_cla, er);
    check(o_q_cla, eq);
    check({12'h0, o_flags_cla}, {12'h0, ef});
    @(posedge i_sys_clk);
  endtask : exec
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    exec(mw(1'b0, BSA_SM_ZERO, 1'b1, BSA_DEST_LOAD, BSA_OP_PASS_D, 16'h7fff),
      16'h7fff, 16'h7fff, 4'h0, 1'b0);
    exec(mw(1'b0, BSA_SM_ZERO, 1'b0, BSA_DEST_LOAD, BSA_OP_ADD, 16'h0001),
      16'h8000, 16'h7fff, 4'h6, 1'b0);
    exec(mw(1'b0, BSA_SM_ZERO, 1'b0, BSA_DEST_LOAD, BSA_OP_ADD, 16'h8000),
      16'h0000, 16'h7fff, 4'hb, 1'b0);
    $display("arithmetic flags done");
    rd(`BSA_REG_STATUS, rv);
    check(rv[15:0], 16'h000f);
    rd(`BSA_REG_STATUS, rv);
    check(rv[15:0], 16'h0000);
    rd(`BSA_REG_FLAGS, rv);
    check(rv[15:0], 16'h000b);
    rd(4'h2, rv);
    check(rv[15:0], 16'h0000);
    wr(`BSA_REG_MASK, 32'h1);
    rd(`BSA_REG_MASK, rv);
    check(rv[15:0], 16'h0001);
    // subtract of zero with carry in gives zero and a carry out
    exec(mw(1'b1, BSA_SM_ZERO, 1'b0, BSA_DEST_LOAD, BSA_OP_SUB, 16'h0000),
      16'h0000, 16'h7fff, 4'h9, 1'b1);
    rd(`BSA_REG_STATUS, rv);
    check(rv[15:0], 16'h0009);
    irq_is(1'b0);
    $display("register port done");
    for (int m = 0; m < 4; m++) begin
      for (int up = 0; up < 2; up++) begin
        exec(mw(1'b0, BSA_SM_ZERO, 1'b1, BSA_DEST_LOAD, BSA_OP_PASS_D, 16'h8000),
          16'h8000, 16'h8000, 4'h4, 1'b0);
        exec(mw(1'b0, BSA_SM_ZERO, 1'b0, BSA_DEST_LOAD, BSA_OP_PASS_D, 16'h4003),
          16'h4003, 16'h8000, 4'h0, 1'b0);
        // result 4003 and register 8000 make every mode's inserted bits differ
        a = up ? BIT_IN_A[m] : BIT_IN_B[m];
        qi = up ? BIT_IN_B[m] : BIT_IN_A[m];
        exec(mw(1'b0, bsa_smode_e'(m), 1'b1, up ? BSA_DEST_UP : BSA_DEST_DOWN, BSA_OP_PASS_ACC, 16'h0),
          up ? {15'h4003, a} : {a, 15'h2001}, up ? {15'h0000, qi} : {qi, 15'h4000},
          4'h0, 1'b0);
      end
    end
    $display("shift modes done");
    end_sim();
  end
endmodule : bit_slice_array_expansion_test
`default_nettype wire
